// ### verilog/gsom_params.svh
// Offsets, field positions, reset values and the nominal ring oscillator rate for the status/mode pair
`ifndef GSOM_PARAMS_SVH
`define GSOM_PARAMS_SVH

// ********************
// Register offsets
// ********************
`define ADDR_GLOBAL_STATUS 12'h000
`define ADDR_OPERATING_MODE_ZERO 12'h001
`define ADDR_VIRTUAL_BASE 12'h080
`define ADDR_VIRTUAL_SFR 12'h0C0

// ********************
// Status field positions
// ********************
`define ST_CRYSTAL_FAILED 6
`define ST_POWER_ON_RESET 5
`define ST_WATCHDOG_RESET 4
`define ST_CURRENT_ORDER 3
`define ST_VOLTAGE_ORDER 2
`define ST_SECOND_REVERSE 1
`define ST_FIRST_REVERSE 0

// ********************
// Mode field positions, reset values and write mask
// ********************
`define OM_EXTERNAL_CLOCK 4
`define OM_FIRMWARE_RESTART 3
`define OM_PROCESSING_DISABLE 2
`define OM_LOW_POWER 1
`define STATUS_RESET 8'h00
`define MODE_RESET 8'h00
`define MODE_WRITE_MASK 8'h1E

// ********************
// Nominal ring oscillator rate
// ********************
`define RING_FREQ_MHZ 1

`endif

// ### verilog/gsom_pkg.sv
// Types shared by the status/mode register block
package gsom_pkg;

	// Host register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [7:0] wdata;
	} host_req_s;

	// Live device conditions that feed the status register
	typedef struct packed {
		logic crystal_failed;
		logic current_phase_order;
		logic voltage_phase_order;
		logic second_pulse_reverse;
		logic first_pulse_reverse;
	} dev_cond_s;

	// Cause of the reset that was just released
	typedef enum logic [1:0] {
		CAUSE_NONE = 2'b00,
		CAUSE_POR = 2'b01,
		CAUSE_WDT = 2'b10
	} reset_cause_e;

	// Firmware restart sequencing
	typedef enum logic [1:0] {
		RST_IDLE = 2'b00,
		RST_REQ = 2'b01,
		RST_WAIT = 2'b10
	} restart_state_e;

endpackage : gsom_pkg

// ### verilog/global_status_opmode_regs.sv
// Global status and operating mode register pair of the metering front end
`timescale 1ns/1ps
`include "gsom_params.svh"

module global_status_opmode_regs
	import gsom_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Host register access
	input wire host_req_s req_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	// Reset cause, sampled in the first cycle after release
	input wire reset_cause_e reset_cause_i,
	// Live device conditions
	input wire dev_cond_s cond_i,
	// Restart handshake with the firmware core
	input wire logic restart_done_i,
	output logic firmware_restart_o,
	// Clocking and processing controls
	output logic external_clock_select_o,
	output logic crystal_osc_enable_o,
	output logic processing_disable_o,
	output logic low_power_clocking_o,
	// Degraded operation indications
	output logic energy_inaccurate_o,
	output logic serial_slow_o
);

	// ********************
	// Address decode
	// ********************
	// Decode is pure combinational so a write lands on the next edge
	wire logic sel_status = req_i.addr == `ADDR_GLOBAL_STATUS;
	wire logic sel_mode = req_i.addr == `ADDR_OPERATING_MODE_ZERO;
	wire logic sel_virtual = req_i.addr >= `ADDR_VIRTUAL_BASE;
	wire logic wr_status = req_i.wr & sel_status;
	wire logic wr_mode = req_i.wr & sel_mode & ~sel_virtual;

	// ********************
	// State
	// ********************
	logic [7:0] global_status;
	logic [7:0] operating_mode_zero;
	logic power_on_reset_flag;
	logic watchdog_reset_flag;
	logic cause_taken;
	restart_state_e restart_state;
	restart_state_e next_restart_state;
	logic [7:0] next_mode;
	logic [7:0] read_mux;

	// ********************
	// Reset cause flags
	// ********************
	// The cause arrives on a port, so it is caught by a clocked process
	// in the first cycle after release, never by the reset itself.
	// Cause capture has priority over a host clear in the same cycle.
	wire logic take_cause = ~cause_taken;
	wire logic set_por = take_cause & (reset_cause_i == CAUSE_POR);
	wire logic set_wdt = take_cause & (reset_cause_i == CAUSE_WDT);
	wire logic clr_por = wr_status & ~req_i.wdata[`ST_POWER_ON_RESET];
	wire logic clr_wdt = wr_status & ~req_i.wdata[`ST_WATCHDOG_RESET];
	// A firmware restart counts as a power-on for reporting purposes
	wire logic restart_por = restart_state == RST_WAIT & restart_done_i;

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			cause_taken <= 1'b0;
		else
			cause_taken <= 1'b1;
	end

	// Power-on flag: set wins over host clear
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			power_on_reset_flag <= 1'b0;
		else if (set_por | restart_por)
			power_on_reset_flag <= 1'b1;
		else if (clr_por)
			power_on_reset_flag <= 1'b0;
	end

	// Watchdog flag: set wins over host clear
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			watchdog_reset_flag <= 1'b0;
		else if (set_wdt)
			watchdog_reset_flag <= 1'b1;
		else if (clr_wdt)
			watchdog_reset_flag <= 1'b0;
	end

	// ********************
	// Status register assembly
	// ********************
	// Live conditions are registered once; bit 7 stays zero
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			global_status <= `STATUS_RESET;
		else
		begin
			global_status[7] <= 1'b0;
			global_status[`ST_CRYSTAL_FAILED] <= cond_i.crystal_failed;
			global_status[`ST_POWER_ON_RESET] <= power_on_reset_flag;
			global_status[`ST_WATCHDOG_RESET] <= watchdog_reset_flag;
			global_status[`ST_CURRENT_ORDER] <= cond_i.current_phase_order;
			global_status[`ST_VOLTAGE_ORDER] <= cond_i.voltage_phase_order;
			global_status[`ST_SECOND_REVERSE] <= cond_i.second_pulse_reverse;
			global_status[`ST_FIRST_REVERSE] <= cond_i.first_pulse_reverse;
		end
	end

	// ********************
	// Firmware restart sequencer
	// ********************
	// Request goes out, then the bit is held until the core reports done
	always_comb
	begin
		next_restart_state = restart_state;
		case (restart_state)
			RST_IDLE:
				if (operating_mode_zero[`OM_FIRMWARE_RESTART])
					next_restart_state = RST_REQ;
			RST_REQ:
				next_restart_state = RST_WAIT;
			RST_WAIT:
				if (restart_done_i)
					next_restart_state = RST_IDLE;
			default:
				next_restart_state = RST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			restart_state <= RST_IDLE;
		else
			restart_state <= next_restart_state;
	end

	// ********************
	// Mode register
	// ********************
	// Self-clear of the restart bit wins over a host rewrite
	always_comb
	begin
		next_mode = operating_mode_zero;
		if (wr_mode)
			next_mode = req_i.wdata & `MODE_WRITE_MASK;
		if (restart_por)
			next_mode[`OM_FIRMWARE_RESTART] = 1'b0;
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			operating_mode_zero <= `MODE_RESET;
		else
			operating_mode_zero <= next_mode;
	end

	// ********************
	// Read path
	// ********************
	// Unmapped and virtual addresses read zero here; the virtual map
	// is served elsewhere and is never writable through this block.
	assign read_mux = sel_status ? global_status :
		sel_mode ? operating_mode_zero : 8'h00;

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rdata_o <= 8'h00;
			rvalid_o <= 1'b0;
		end
		else
		begin
			rdata_o <= req_i.rd ? read_mux : 8'h00;
			rvalid_o <= req_i.rd;
		end
	end

	// ********************
	// Control outputs
	// ********************
	// Registered so every output comes from a flip-flop
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			firmware_restart_o <= 1'b0;
			external_clock_select_o <= 1'b0;
			crystal_osc_enable_o <= 1'b1;
			processing_disable_o <= 1'b0;
			low_power_clocking_o <= 1'b0;
			energy_inaccurate_o <= 1'b0;
			serial_slow_o <= 1'b0;
		end
		else
		begin
			firmware_restart_o <= restart_state == RST_REQ;
			external_clock_select_o <=
				operating_mode_zero[`OM_EXTERNAL_CLOCK];
			crystal_osc_enable_o <=
				~operating_mode_zero[`OM_EXTERNAL_CLOCK];
			processing_disable_o <=
				operating_mode_zero[`OM_PROCESSING_DISABLE];
			// Host must retune crystal settings after this switch
			low_power_clocking_o <=
				operating_mode_zero[`OM_LOW_POWER];
			energy_inaccurate_o <= global_status[`ST_CRYSTAL_FAILED];
			serial_slow_o <= global_status[`ST_CRYSTAL_FAILED];
		end
	end

endmodule : global_status_opmode_regs

// ### test/gsom_props.sv
// Concurrent checks on the status/mode register block ports
`timescale 1ns/1ps
`include "gsom_params.svh"
module gsom_props
	import gsom_pkg::*;
(
	// Clock, reset, host side and device conditions
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire host_req_s req_i,
	input wire dev_cond_s cond_i,
	// Watched outputs
	input wire logic rvalid_o,
	input wire logic firmware_restart_o,
	input wire logic external_clock_select_o,
	input wire logic crystal_osc_enable_o,
	input wire logic processing_disable_o,
	input wire logic low_power_clocking_o,
	input wire logic energy_inaccurate_o,
	input wire logic serial_slow_o
);
	// One clock domain, so clocking and disable are shared
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	// Host write aimed at the mode register
	wire logic mw = req_i.wr && req_i.addr == `ADDR_OPERATING_MODE_ZERO;
	chk_read_answer: assert property (req_i.rd |=> rvalid_o)
		else $error("read got no answer");
	chk_ext_clock: assert property (mw |-> ##2
		external_clock_select_o == $past(req_i.wdata[4], 2))
		else $error("clock select does not follow write");
	chk_osc_off: assert property (
		crystal_osc_enable_o != external_clock_select_o)
		else $error("oscillator enable not opposite of select");
	chk_proc_off: assert property (mw |-> ##2
		processing_disable_o == $past(req_i.wdata[2], 2))
		else $error("processing disable does not follow write");
	chk_low_power: assert property (mw |-> ##2
		low_power_clocking_o == $past(req_i.wdata[1], 2))
		else $error("low power does not follow write");
	chk_restart_pulse: assert property (
		firmware_restart_o |=> !firmware_restart_o)
		else $error("restart request longer than a cycle");
	chk_restart_req: assert property (
		mw && req_i.wdata[3] && !firmware_restart_o |-> ##3 firmware_restart_o)
		else $error("restart request missing");
	chk_fail_flag: assert property (
		cond_i.crystal_failed [*3] |-> ##1 energy_inaccurate_o)
		else $error("crystal failure not flagged");
	chk_slow_bus: assert property (
		cond_i.crystal_failed [*3] |-> ##1 serial_slow_o)
		else $error("slow serial bus not flagged");
	// Flags must drop again once the crystal is healthy
	chk_fail_clear: assert property (
		(!cond_i.crystal_failed) [*3] |->
		##1 (!energy_inaccurate_o && !serial_slow_o))
		else $error("fallback flags stay up on a good crystal");
endmodule : gsom_props

// ### test/gsom_host_model.sv
// Host controller model issuing single-byte register cycles
`timescale 1ns/1ps
`include "gsom_params.svh"
module gsom_host_model
	import gsom_pkg::*;
(
	// Clock and request toward the register block
	input wire logic core_clk_i,
	output host_req_s req_o
);
	// Idle at start
	initial req_o = '0;
	// A request stands one cycle; on release both strobes drop to zero and address and data show inverted values
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		@(negedge core_clk_i);
		req_o = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge core_clk_i);
		req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : xfer
	// Reset cause flags are dropped by writing zero once read
	task automatic clear_flags();
		xfer(1'b1, `ADDR_GLOBAL_STATUS, 8'h00);
	endtask : clear_flags
endmodule : gsom_host_model

// ### test/tb_global_status_opmode_regs.sv
// Self-checking bench for the status/mode register pair
`timescale 1ns/1ps
`include "gsom_params.svh"
module tb_global_status_opmode_regs
	import gsom_pkg::*;
;
	localparam logic [11:0] AS = `ADDR_GLOBAL_STATUS;
	localparam logic [11:0] AM = `ADDR_OPERATING_MODE_ZERO;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic done = 1'b0;
	reset_cause_e cause = CAUSE_POR;
	dev_cond_s cond = '0;
	host_req_s req;
	logic [7:0] rdata;
	logic rvalid, fr, ext, osc, pd, lp, ei, ss;
	logic [7:0] exp_q[$];
	logic [11:0] va[4] = '{12'h080, 12'h0C0, 12'h0FF, 12'h005};
	logic [31:0] seed = 32'h0000_94d3;
	int error_cnt = 0;
	int tests_run = 0;
	// 200 MHz clock
	always #2.5 core_clk_i = ~core_clk_i;
	global_status_opmode_regs DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
		.reset_cause_i(cause), .cond_i(cond), .restart_done_i(done),
		.firmware_restart_o(fr), .external_clock_select_o(ext),
		.crystal_osc_enable_o(osc), .processing_disable_o(pd),
		.low_power_clocking_o(lp), .energy_inaccurate_o(ei),
		.serial_slow_o(ss));
	gsom_host_model host (.core_clk_i(core_clk_i), .req_o(req));
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		xs = y ^ (y << 5);
	endfunction : xs
	// Status as it should read, live bits taken from the driven conditions
	function automatic logic [7:0] st(input logic p, input logic w);
		st = {1'b0, cond[4], p, w, cond[3:0]};
	endfunction : st
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// Note the expected byte first, the monitor pairs it with the answer
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.xfer(1'b0, a, 8'h00);
	endtask : rd
	task automatic rst_seq(input reset_cause_e c);
		rst_i = 1'b1;
		cause = c;
		repeat (6) @(negedge core_clk_i);
		rst_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		cause = CAUSE_NONE;
	endtask : rst_seq
	task automatic end_of_test();
		repeat (3) @(negedge core_clk_i);
		if (error_cnt == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	// Monitor: answers sampled mid-cycle, where they are settled
	always @(negedge core_clk_i)
		if (rvalid === 1'b1)
			chk("rdata", exp_q.size() ? exp_q.pop_front() : 8'hxx, rdata);
	// Watchdog well beyond the expected run length
	initial
	begin
		#20000;
		error_cnt++;
		end_of_test();
	end
	initial
	begin
		rst_seq(CAUSE_POR);
		repeat (6)
		begin
			seed = xs(seed);
			cond = seed[4:0];
			rd(AS, st(1'b1, 1'b0));
		end
		// Fallback flags follow the crystal state both ways
		for (int v = 0; v < 2; v++)
		begin
			cond.crystal_failed = !v;
			repeat (4) @(negedge core_clk_i);
			chk("fallback", {6'h00, !v, !v}, {6'h00, ei, ss});
		end
		host.xfer(1'b1, AS, 8'hFF);
		rd(AS, st(1'b1, 1'b0));
		host.clear_flags();
		rd(AS, st(1'b0, 1'b0));
		rst_seq(CAUSE_WDT);
		rd(AS, st(1'b0, 1'b1));
		rd(AM, 8'h00);
		host.clear_flags();
		rd(AS, st(1'b0, 1'b0));
		host.xfer(1'b1, AM, 8'hF7);
		rd(AM, 8'h16);
		chk("ctl", 8'h0B, {4'h0, ext, osc, pd, lp});
		host.xfer(1'b1, AM, 8'h16);
		host.xfer(1'b1, AM, 8'h1E);
		for (int i = 0; i < 9 && fr !== 1'b1; i++)
			@(negedge core_clk_i);
		chk("restart", 8'h01, {7'h00, fr});
		done = 1'b1;
		@(negedge core_clk_i);
		done = 1'b0;
		repeat (2) @(negedge core_clk_i);
		rd(AM, 8'h16);
		rd(AS, st(1'b1, 1'b0));
		chk("ctl", 8'h0B, {4'h0, ext, osc, pd, lp});
		foreach (va[i])
		begin
			seed = xs(seed);
			host.xfer(1'b1, va[i], seed[7:0]);
			rd(va[i], 8'h00);
		end
		rd(AM, 8'h16);
		host.xfer(1'b1, AM, 8'h00);
		rd(AM, 8'h00);
		chk("ctl", 8'h04, {4'h0, ext, osc, pd, lp});
		end_of_test();
	end
endmodule : tb_global_status_opmode_regs
bind global_status_opmode_regs gsom_props props (.core_clk_i(core_clk_i),
	.rst_i(rst_i), .req_i(req_i), .cond_i(cond_i), .rvalid_o(rvalid_o),
	.firmware_restart_o(firmware_restart_o),
	.external_clock_select_o(external_clock_select_o),
	.crystal_osc_enable_o(crystal_osc_enable_o),
	.processing_disable_o(processing_disable_o),
	.low_power_clocking_o(low_power_clocking_o),
	.energy_inaccurate_o(energy_inaccurate_o),
	.serial_slow_o(serial_slow_o));
